// file: pll_timing_generator_defs.vh
// Constants used by the timing generator; its divider and switch cells do not use them.
// Assumes core_clk is the input reference clock, so one cycle is one
// reference period.
`ifndef PLL_TIMING_GENERATOR_DEFS_VH
`define PLL_TIMING_GENERATOR_DEFS_VH

// Lock and start-up waits, in reference clock periods
`define LOCK_FULL_CYCLES      10'd520
`define LOCK_SHORT_CYCLES     10'd10
`define STARTUP_CYCLES        10'd500
`define STRAP_CAPTURE_CYCLE   10'd6

// Boot configuration pin codes
`define BOOT_REF_13           2'h0
`define BOOT_REF_19_2         2'h1
`define BOOT_REF_24           2'h2
`define BOOT_REF_27           2'h3

// Presets: feedback, reference divider, exponent, domain divider (N-1)
`define PRE13_FB              8'h49
`define PRE13_NR              5'h00
`define PRE13_EXP             3'h1
`define PRE13_DIV             6'h09
`define PRE19_FB              8'h27
`define PRE19_NR              5'h00
`define PRE19_EXP             3'h2
`define PRE19_DIV             6'h03
`define PRE24_FB              8'h1f
`define PRE24_NR              5'h00
`define PRE24_EXP             3'h2
`define PRE24_DIV             6'h03
`define PRE27_FB              8'h1f
`define PRE27_NR              5'h00
`define PRE27_EXP             3'h2
`define PRE27_DIV             6'h04

// Source select codes for the processor and system domains
`define SRC_SYS_PLL           1'b0
`define SRC_ARRAY_PROCESSOR_PLL            1'b1

// Multiple-choice divider codes and their divisors (N-1)
`define CHOICE_DIV4           2'h0
`define CHOICE_DIV3           2'h1
`define CHOICE_DIV2           2'h2
`define CHOICE_DIV1           2'h3
`define CHOICE_N4             6'h03
`define CHOICE_N3             6'h02
`define CHOICE_N2             6'h01
`define CHOICE_N1             6'h00

// Packed word of an unmanaged PLL: feedback, reference divider, exponent
`define WORD_FB_MSB           15
`define WORD_FB_LSB           8
`define WORD_NR_MSB           7
`define WORD_NR_LSB           3
`define WORD_EXP_MSB          2
`define WORD_EXP_LSB          0
`define WORD_RESET            16'h0000

`endif

// file: clk_int_divider.v
// Integer clock divider, divide by 1 to 64, setting coded as N-1.
// Assumes a new setting is taken only at the end of a whole output period.
`timescale 1ns/1ps
`default_nettype none
module clk_int_divider #(
   parameter [5:0] RESET_DIV = 6'h00
) (
   input  wire       core_clk,
   input  wire       rst,
   input  wire [5:0] divSetting,
   output wire       clkOut,
   output wire       tick,
   output wire       busy
);
   reg  [5:0] count_reg;
   reg  [5:0] curDiv_reg;
   reg        clkOut_reg;
   wire       wrap;
   wire [5:0] count_next;
   wire [5:0] div_next;
   wire [6:0] half_next;

   assign wrap      = (count_reg == curDiv_reg);
   assign count_next = wrap ? 6'h00 : count_reg + 6'h01;
   // Reload only at a period boundary so no runt pulse appears
   assign div_next  = wrap ? divSetting : curDiv_reg;
   assign half_next = ({1'b0, div_next} + 7'h02) >> 1;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_reg  <= 6'h00;
         curDiv_reg <= RESET_DIV;
         clkOut_reg <= 1'b0;
      end else begin
         count_reg  <= count_next;
         curDiv_reg <= div_next;
         // Divide by one stays high: a level model cannot beat its clock
         clkOut_reg <= ({1'b0, count_next} < half_next);
      end
   end

   assign clkOut = clkOut_reg;
   assign tick   = wrap;
   assign busy   = (curDiv_reg != divSetting);
endmodule // clk_int_divider
`default_nettype wire

// file: clk_glitch_free_switch.v
// Glitch-free two-way clock switch for level clocks on core_clk.
// Assumes both sources are registered levels from the same clock.
`timescale 1ns/1ps
`default_nettype none
module clk_glitch_free_switch (
   input  wire core_clk,
   input  wire rst,
   input  wire clkA,
   input  wire clkB,
   input  wire selB,
   output wire clkOut,
   output wire busy
);
   reg  cur_reg;
   reg  clkOut_reg;
   wire newSrc;

   assign newSrc = selB ? clkB : clkA;

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_reg    <= 1'b0;
         clkOut_reg <= 1'b0;
      end else if ((selB != cur_reg) && !clkOut_reg) begin
         // Park low until the new source is low too
         clkOut_reg <= 1'b0;
         if (!newSrc) begin
            cur_reg <= selB;
         end
      end else begin
         clkOut_reg <= cur_reg ? clkB : clkA;
      end
   end

   assign clkOut = clkOut_reg;
   assign busy   = (selB != cur_reg);
endmodule // clk_glitch_free_switch
`default_nettype wire

// file: pll_timing_generator.v
// Timing generator: five PLL settings, managed updates of the system and
// array-processor PLLs, domain dividers and glitch-free domain switching.
// Assumes core_clk is the input reference; clock outputs are level models.
`timescale 1ns/1ps
`default_nettype none
`include "pll_timing_generator_defs.vh"
module pll_timing_generator (
   input  wire        core_clk,
   input  wire        rst,
   input  wire [1:0]  bootCfgPins,
   input  wire [7:0]  sysFeedbackSetting,
   input  wire [4:0]  sysReferenceDividerSetting,
   input  wire [2:0]  sysExpSetting,
   input  wire [7:0]  apFeedbackSetting,
   input  wire [4:0]  apReferenceDividerSetting,
   input  wire [2:0]  apExpSetting,
   input  wire [5:0]  cpuDivSetting,
   input  wire [5:0]  sysDivSetting,
   input  wire        cpuSrcSetting,
   input  wire        sysSrcSetting,
   input  wire        kickSysPll,
   input  wire        kickApPll,
   input  wire        kickDivider,
   input  wire        kickSource,
   input  wire [5:0]  arrayMemDivSetting,
   input  wire [1:0]  arrayCoreChoice,
   input  wire [5:0]  memDivSetting,
   input  wire [5:0]  ifRefDivSetting,
   input  wire [15:0] ifPllWordIn,
   input  wire [15:0] dispPllWordIn,
   input  wire [15:0] memPllWordIn,
   output wire        cpuClk,
   output wire        sysClk,
   output wire        arrayMemClk,
   output wire        arrayCoreClock,
   output wire        doubleRateMemoryClock,
   output wire        memClk,
   output wire        ifRefClk,
   output wire        clocksReady,
   output wire [1:0]  bootPreset,
   output wire        sysPllLocked,
   output wire        apPllLocked,
   output wire        sysPllUpdateBusy,
   output wire        apPllUpdateBusy,
   output wire        dividerUpdateBusy,
   output wire        sourceUpdateBusy,
   output wire [9:0]  sysPllRatioNum,
   output wire [12:0] sysPllRatioDen,
   output wire [9:0]  apPllRatioNum,
   output wire [12:0] apPllRatioDen,
   output wire [15:0] ifPllWord,
   output wire [15:0] dispPllWord,
   output wire [15:0] memPllWord
);
   localparam [3:0] ST_IDLE   = 4'b0001;
   localparam [3:0] ST_APPLY  = 4'b0010;
   localparam [3:0] ST_LOCK   = 4'b0100;
   localparam [3:0] ST_SWITCH = 4'b1000;

   // Job bits, also the order of the pending bits
   localparam [3:0] JOB_SYS = 4'b0001;
   localparam [3:0] JOB_AP  = 4'b0010;
   localparam [3:0] JOB_DIV = 4'b0100;
   localparam [3:0] JOB_SRC = 4'b1000;

   // Ratio denominator of a PLL: (R+1) shifted by the exponent
   function [12:0] ratioDen;
      input [4:0] refDiv;
      input [2:0] expSet;
      begin
         ratioDen = ({8'h00, refDiv} + 13'h0001) << expSet;
      end
   endfunction

   // Ratio numerator of a PLL: twice (F+1)
   function [9:0] ratioNum;
      input [7:0] fb;
      begin
         ratioNum = {({1'b0, fb} + 9'h001), 1'b0};
      end
   endfunction

   // Preset word {fb, nr, exp, div} for each boot code
   function [21:0] presetWord;
      input [1:0] code;
      begin
         case (code)
            `BOOT_REF_13:   presetWord = {`PRE13_FB, `PRE13_NR,
                                          `PRE13_EXP, `PRE13_DIV};
            `BOOT_REF_19_2: presetWord = {`PRE19_FB, `PRE19_NR,
                                          `PRE19_EXP, `PRE19_DIV};
            `BOOT_REF_27:   presetWord = {`PRE27_FB, `PRE27_NR,
                                          `PRE27_EXP, `PRE27_DIV};
            default:        presetWord = {`PRE24_FB, `PRE24_NR,
                                          `PRE24_EXP, `PRE24_DIV};
         endcase
      end
   endfunction

   // Multiple-choice divider: /4, /3, /2, /1
   function [5:0] choiceDiv;
      input [1:0] code;
      begin
         case (code)
            `CHOICE_DIV4: choiceDiv = `CHOICE_N4;
            `CHOICE_DIV3: choiceDiv = `CHOICE_N3;
            `CHOICE_DIV2: choiceDiv = `CHOICE_N2;
            default:      choiceDiv = `CHOICE_N1;
         endcase
      end
   endfunction

   // Lowest pending job wins
   function [3:0] pickJob;
      input [3:0] pend;
      begin
         pickJob = pend & (~pend + 4'h1);
      end
   endfunction

   reg  [1:0]  strapS1_reg;
   reg  [1:0]  strapS2_reg;
   reg  [1:0]  strapS3_reg;
   reg  [1:0]  strapFilt_reg;
   reg  [1:0]  bootPreset_reg;
   reg  [9:0]  startCount_reg;
   reg         startDone_reg;
   reg  [3:0]  state_reg;
   reg  [3:0]  job_reg;
   reg  [3:0]  pending_reg;
   reg  [3:0]  pending_next;
   reg  [3:0]  doneMask;
   reg  [9:0]  lockCount_reg;
   reg  [7:0]  sysFb_reg;
   reg  [4:0]  sysNr_reg;
   reg  [2:0]  sysExp_reg;
   reg  [7:0]  apFb_reg;
   reg  [4:0]  apNr_reg;
   reg  [2:0]  apExp_reg;
   reg         sysLocked_reg;
   reg         apLocked_reg;
   reg  [5:0]  cpuDiv_reg;
   reg  [5:0]  sysDiv_reg;
   reg         cpuSrc_reg;
   reg         sysSrc_reg;
   reg  [15:0] ifWord_reg;
   reg  [15:0] dispWord_reg;
   reg  [15:0] memWord_reg;
   reg         refHalf_reg;
   reg         memHalf_reg;
   wire [21:0] preset;
   wire        sysExpOnly;
   wire        apExpOnly;
   wire [1:0]  domClk;
   wire [1:0]  domSwBusy;
   wire [1:0]  domDivBusy;
   wire [5:0]  domDiv [0:1];
   wire [1:0]  domSrc;
   wire [1:0]  domLocked;
   wire        memTick;

   assign preset = presetWord(strapFilt_reg);
   assign sysExpOnly = (sysFeedbackSetting == sysFb_reg) &&
                       (sysReferenceDividerSetting == sysNr_reg);
   assign apExpOnly  = (apFeedbackSetting == apFb_reg) &&
                       (apReferenceDividerSetting == apNr_reg);

   // Pins pass three flops; a change counts once two and three agree
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strapS1_reg   <= `BOOT_REF_24;
         strapS2_reg   <= `BOOT_REF_24;
         strapS3_reg   <= `BOOT_REF_24;
         strapFilt_reg <= `BOOT_REF_24;
      end else begin
         strapS1_reg <= bootCfgPins;
         strapS2_reg <= strapS1_reg;
         strapS3_reg <= strapS2_reg;
         if (strapS2_reg == strapS3_reg) begin
            strapFilt_reg <= strapS3_reg;
         end
      end
   end

   // Kicks set, completion clears; a kick in the clearing cycle stays
   always @* begin
      doneMask = 4'h0;
      if ((state_reg == ST_LOCK) && (lockCount_reg == 10'd1)) begin
         doneMask = job_reg;
      end
      if ((state_reg == ST_SWITCH) && !(|domSwBusy) && !(|domDivBusy)) begin
         doneMask = job_reg;
      end
      pending_next = (pending_reg & ~doneMask) |
                     {kickSource, kickDivider, kickApPll, kickSysPll};
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bootPreset_reg <= `BOOT_REF_24;
         startCount_reg <= 10'd0;
         startDone_reg  <= 1'b0;
         state_reg      <= ST_IDLE;
         job_reg        <= 4'h0;
         pending_reg    <= 4'h0;
         lockCount_reg  <= 10'd0;
         sysFb_reg      <= `PRE24_FB;
         sysNr_reg      <= `PRE24_NR;
         sysExp_reg     <= `PRE24_EXP;
         apFb_reg       <= `PRE24_FB;
         apNr_reg       <= `PRE24_NR;
         apExp_reg      <= `PRE24_EXP;
         sysLocked_reg  <= 1'b0;
         apLocked_reg   <= 1'b0;
         cpuDiv_reg     <= `PRE24_DIV;
         sysDiv_reg     <= `PRE24_DIV;
         cpuSrc_reg     <= `SRC_SYS_PLL;
         sysSrc_reg     <= `SRC_SYS_PLL;
      end else begin
         pending_reg <= pending_next;
         if (!startDone_reg) begin
            startCount_reg <= startCount_reg + 10'd1;
            if (startCount_reg == `STRAP_CAPTURE_CYCLE) begin
               // Boot pins pick the preset for both managed PLLs
               bootPreset_reg <= strapFilt_reg;
               {sysFb_reg, sysNr_reg, sysExp_reg} <= preset[21:6];
               {apFb_reg, apNr_reg, apExp_reg}    <= preset[21:6];
               cpuDiv_reg <= preset[5:0];
               sysDiv_reg <= preset[5:0];
            end
            if (startCount_reg == `STARTUP_CYCLES - 10'd1) begin
               startDone_reg <= 1'b1;
               sysLocked_reg <= 1'b1;
               apLocked_reg  <= 1'b1;
            end
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  if (|pending_reg) begin
                     job_reg   <= pickJob(pending_reg);
                     state_reg <= ST_APPLY;
                  end
               end
               ST_APPLY: begin
                  case (job_reg)
                     JOB_SYS: begin
                        sysFb_reg     <= sysFeedbackSetting;
                        sysNr_reg     <= sysReferenceDividerSetting;
                        sysExp_reg    <= sysExpSetting;
                        sysLocked_reg <= 1'b0;
                        lockCount_reg <= sysExpOnly ? `LOCK_SHORT_CYCLES
                                                    : `LOCK_FULL_CYCLES;
                        state_reg     <= ST_LOCK;
                     end
                     JOB_AP: begin
                        apFb_reg      <= apFeedbackSetting;
                        apNr_reg      <= apReferenceDividerSetting;
                        apExp_reg     <= apExpSetting;
                        apLocked_reg  <= 1'b0;
                        lockCount_reg <= apExpOnly ? `LOCK_SHORT_CYCLES
                                                   : `LOCK_FULL_CYCLES;
                        state_reg     <= ST_LOCK;
                     end
                     JOB_DIV: begin
                        cpuDiv_reg <= cpuDivSetting;
                        sysDiv_reg <= sysDivSetting;
                        state_reg  <= ST_SWITCH;
                     end
                     default: begin
                        cpuSrc_reg <= cpuSrcSetting;
                        sysSrc_reg <= sysSrcSetting;
                        state_reg  <= ST_SWITCH;
                     end
                  endcase
               end
               ST_LOCK: begin
                  lockCount_reg <= lockCount_reg - 10'd1;
                  if (lockCount_reg == 10'd1) begin
                     sysLocked_reg <= sysLocked_reg | job_reg[0];
                     apLocked_reg  <= apLocked_reg | job_reg[1];
                     state_reg     <= ST_IDLE;
                  end
               end
               ST_SWITCH: begin
                  if (!(|domSwBusy) && !(|domDivBusy)) begin
                     state_reg <= ST_IDLE;
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // Unmanaged PLLs follow software at once; gating is software's job
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ifWord_reg   <= `WORD_RESET;
         dispWord_reg <= `WORD_RESET;
         memWord_reg  <= `WORD_RESET;
         refHalf_reg  <= 1'b0;
         memHalf_reg  <= 1'b0;
      end else begin
         ifWord_reg   <= ifPllWordIn;
         dispWord_reg <= dispPllWordIn;
         memWord_reg  <= memPllWordIn;
         refHalf_reg  <= ~refHalf_reg;
         if (memTick) begin
            memHalf_reg <= ~memHalf_reg;
         end
      end
   end

   assign domDiv[0] = cpuDiv_reg;
   assign domDiv[1] = sysDiv_reg;
   assign domSrc    = {sysSrc_reg, cpuSrc_reg};

   // Fall back to the reference half-rate clock while the source locks
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : gDomain
         wire divClk;
         assign domLocked[g] = (domSrc[g] == `SRC_ARRAY_PROCESSOR_PLL) ? apLocked_reg
                                                          : sysLocked_reg;
         clk_int_divider #(.RESET_DIV(`PRE24_DIV)) uDiv (
            .core_clk   (core_clk),
            .rst        (rst),
            .divSetting (domDiv[g]),
            .clkOut     (divClk),
            .tick       (),
            .busy       (domDivBusy[g])
         );
         clk_glitch_free_switch uSwitch (
            .core_clk (core_clk),
            .rst      (rst),
            .clkA     (refHalf_reg),
            .clkB     (divClk),
            .selB     (domLocked[g]),
            .clkOut   (domClk[g]),
            .busy     (domSwBusy[g])
         );
      end
   endgenerate

   clk_int_divider #(.RESET_DIV(6'h00)) uArrayMem (
      .core_clk   (core_clk),
      .rst        (rst),
      .divSetting (arrayMemDivSetting),
      .clkOut     (arrayMemClk),
      .tick       (),
      .busy       ()
   );

   clk_int_divider #(.RESET_DIV(`CHOICE_N4)) uArrayCore (
      .core_clk   (core_clk),
      .rst        (rst),
      .divSetting (choiceDiv(arrayCoreChoice)),
      .clkOut     (arrayCoreClock),
      .tick       (),
      .busy       ()
   );

   clk_int_divider #(.RESET_DIV(6'h00)) uMem2x (
      .core_clk   (core_clk),
      .rst        (rst),
      .divSetting (memDivSetting),
      .clkOut     (doubleRateMemoryClock),
      .tick       (memTick),
      .busy       ()
   );

   // Fed only by its own settings, so system changes leave it alone
   clk_int_divider #(.RESET_DIV(6'h00)) uIfRef (
      .core_clk   (core_clk),
      .rst        (rst),
      .divSetting (ifRefDivSetting),
      .clkOut     (ifRefClk),
      .tick       (),
      .busy       ()
   );

   assign cpuClk            = domClk[0];
   assign sysClk            = domClk[1];
   assign memClk            = memHalf_reg;
   assign clocksReady       = startDone_reg;
   assign bootPreset        = bootPreset_reg;
   assign sysPllLocked      = sysLocked_reg;
   assign apPllLocked       = apLocked_reg;
   assign sysPllUpdateBusy  = pending_reg[0];
   assign apPllUpdateBusy   = pending_reg[1];
   assign dividerUpdateBusy = pending_reg[2];
   assign sourceUpdateBusy  = pending_reg[3];
   assign sysPllRatioNum    = ratioNum(sysFb_reg);
   assign sysPllRatioDen    = ratioDen(sysNr_reg, sysExp_reg);
   assign apPllRatioNum     = ratioNum(apFb_reg);
   assign apPllRatioDen     = ratioDen(apNr_reg, apExp_reg);
   assign ifPllWord         = ifWord_reg;
   assign dispPllWord       = dispWord_reg;
   assign memPllWord        = memWord_reg;
endmodule // pll_timing_generator
`default_nettype wire

// file: ref_oscillator.sv
// Reference oscillator model feeding the timing generator.
// Assumes the bench wants a free-running 10 MHz reference.
`timescale 1ns/1ps
`default_nettype none
module ref_oscillator #(
   parameter int HALF = 50
) (
   output logic core_clk
);
   // Runs free: a crystal never stops between uses
   initial core_clk = 1'b0;
   always #HALF core_clk = ~core_clk;
endmodule // ref_oscillator
`default_nettype wire

// file: pll_timing_generator_assertions.sv
// Port checker for the timing generator.
// Assumes bind to pll_timing_generator and core_clk as reference.
`timescale 1ns/1ps
`default_nettype none
module pll_timing_generator_assertions (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [1:0]  bootCfgPins,
   input wire logic        kickSysPll,
   input wire logic        clocksReady,
   input wire logic [1:0]  bootPreset,
   input wire logic        sysPllLocked,
   input wire logic        sysPllUpdateBusy,
   input wire logic        apPllUpdateBusy,
   input wire logic [9:0]  sysPllRatioNum,
   input wire logic [9:0]  apPllRatioNum,
   input wire logic [15:0] ifPllWordIn,
   input wire logic [15:0] ifPllWord
);
   logic [9:0] upCnt;
   // Saturates so a long run never wraps back to 500
   always @(posedge core_clk or posedge rst) begin
      if (rst)
         upCnt <= 10'h000;
      else if (upCnt != 10'h3ff)
         upCnt <= upCnt + 10'h001;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence kickTaken;
      kickSysPll ##1 sysPllUpdateBusy;
   endsequence
   ready_wait_a: assert property ($rose(clocksReady)
      |-> upCnt == 10'h1f4)
      else $error("ready not at 500 cycles");
   ready_hold_a: assert property (clocksReady |=> clocksReady)
      else $error("ready dropped");
   preset_pick_a: assert property ($rose(clocksReady)
      |-> bootPreset == bootCfgPins)
      else $error("preset differs from pins");
   kick_busy_a: assert property (kickSysPll |-> kickTaken)
      else $error("kick not recorded");
   lock_drop_a: assert property ($fell(sysPllLocked)
      |-> sysPllUpdateBusy)
      else $error("lock lost without update");
   lock_min_a: assert property ($rose(sysPllLocked)
      |-> !$past(sysPllLocked, 9))
      else $error("lock wait too short");
   busy_clear_a: assert property ($fell(sysPllUpdateBusy)
      |-> sysPllLocked)
      else $error("busy cleared before lock");
   sys_hold_a: assert property (!sysPllUpdateBusy && $past(!sysPllUpdateBusy)
      && $past(clocksReady) |-> $stable(sysPllRatioNum))
      else $error("system ratio moved without kick");
   ap_hold_a: assert property (!apPllUpdateBusy && $past(!apPllUpdateBusy)
      && $past(clocksReady) |-> $stable(apPllRatioNum))
      else $error("ap ratio moved without kick");
   word_copy_a: assert property (!$past(rst)
      |-> ifPllWord == $past(ifPllWordIn))
      else $error("word copy wrong");
endmodule // pll_timing_generator_assertions
bind pll_timing_generator pll_timing_generator_assertions i_chk (.core_clk,
   .rst, .bootCfgPins, .kickSysPll, .clocksReady, .bootPreset,
   .sysPllLocked, .sysPllUpdateBusy, .apPllUpdateBusy, .sysPllRatioNum,
   .apPllRatioNum, .ifPllWordIn, .ifPllWord);
`default_nettype wire

// file: pll_timing_generator_tb.sv
// Self-checking bench for the timing generator.
// Assumes ref_oscillator as clock and the checker bound in its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
   end end
module pll_timing_generator_tb;
   wire         core_clk;
   logic        rst = 1'b1;
   logic [1:0]  bootCfgPins = 2'h2, arrayCoreChoice = 2'h0;
   logic [7:0]  sysFeedbackSetting = 8'h1f, apFeedbackSetting = 8'h1f;
   logic [4:0]  sysReferenceDividerSetting = 5'h00;
   logic [4:0]  apReferenceDividerSetting = 5'h00;
   logic [2:0]  sysExpSetting = 3'h2, apExpSetting = 3'h2;
   logic [5:0]  cpuDivSetting = 6'h03, sysDivSetting = 6'h03;
   logic [5:0]  arrayMemDivSetting = 6'h03, memDivSetting = 6'h01;
   logic [5:0]  ifRefDivSetting = 6'h01;
   logic        cpuSrcSetting = 1'b0, sysSrcSetting = 1'b0;
   logic        kickSysPll = 1'b0, kickApPll = 1'b0;
   logic        kickDivider = 1'b0, kickSource = 1'b0;
   logic [15:0] ifPllWordIn = 16'h0000, dispPllWordIn = 16'h0000;
   logic [15:0] memPllWordIn = 16'h0000;
   wire         cpuClk, sysClk, arrayMemClk, arrayCoreClock, memClk;
   wire         doubleRateMemoryClock, ifRefClk, clocksReady;
   wire         sysPllLocked, apPllLocked, sysPllUpdateBusy, apPllUpdateBusy;
   wire         dividerUpdateBusy, sourceUpdateBusy;
   wire [1:0]   bootPreset;
   wire [9:0]   sysPllRatioNum, apPllRatioNum;
   wire [12:0]  sysPllRatioDen, apPllRatioDen;
   wire [15:0]  ifPllWord, dispPllWord, memPllWord;
   wire [4:0]   clks = {memClk, ifRefClk, arrayCoreClock, arrayMemClk,
      cpuClk};
   int          n_mismatch = 0, checked = 0, len, p;
   ref_oscillator i_ref_oscillator (.core_clk);
   pll_timing_generator i_pll_timing_generator (.core_clk, .rst, .bootCfgPins,
      .sysFeedbackSetting, .sysReferenceDividerSetting, .sysExpSetting,
      .apFeedbackSetting, .apReferenceDividerSetting, .apExpSetting,
      .cpuDivSetting, .sysDivSetting, .cpuSrcSetting, .sysSrcSetting,
      .kickSysPll, .kickApPll, .kickDivider, .kickSource, .arrayMemDivSetting,
      .arrayCoreChoice, .memDivSetting, .ifRefDivSetting, .ifPllWordIn,
      .dispPllWordIn, .memPllWordIn, .cpuClk, .sysClk, .arrayMemClk,
      .arrayCoreClock, .doubleRateMemoryClock, .memClk, .ifRefClk,
      .clocksReady, .bootPreset, .sysPllLocked, .apPllLocked,
      .sysPllUpdateBusy, .apPllUpdateBusy, .dividerUpdateBusy,
      .sourceUpdateBusy, .sysPllRatioNum, .sysPllRatioDen, .apPllRatioNum,
      .apPllRatioDen, .ifPllWord, .dispPllWord, .memPllWord);
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic kickOne(input int k);
      tick(1);
      {kickSource, kickDivider, kickApPll, kickSysPll} = 4'h1 << k;
      tick(1);
      {kickSource, kickDivider, kickApPll, kickSysPll} = 4'h0;
   endtask
   // Kick a managed PLL and count cycles with lock low
   task automatic lockRun(input int k);
      int n;
      n = 0;
      len = 0;
      kickOne(k);
      while ((k ? apPllLocked : sysPllLocked) !== 1'b0 && n < 10) begin
         tick(1);
         n++;
      end
      while ((k ? apPllLocked : sysPllLocked) !== 1'b1 && len < 1000) begin
         tick(1);
         len++;
      end
      tick(2);
      `CHK("busy", 1'b0, k ? apPllUpdateBusy : sysPllUpdateBusy)
   endtask
   task automatic waitBusy(input int k);
      int n;
      n = 0;
      while ((k ? sourceUpdateBusy : dividerUpdateBusy) !== 1'b0 && n < 300) begin
         tick(1);
         n++;
      end
   endtask
   task automatic waitLvl(input int s, input logic v, inout int c);
      int n;
      n = 0;
      while (clks[s] !== v && n < 200) begin
         tick(1);
         c++;
         n++;
      end
   endtask
   // Second pass only: the first may still show the old divisor
   task automatic period(input int s);
      waitLvl(s, 1'b0, p);
      waitLvl(s, 1'b1, p);
      p = 0;
      waitLvl(s, 1'b0, p);
      waitLvl(s, 1'b1, p);
   endtask
   task automatic complete_run;
      $display("Counts: %0d checked, %0d mismatched", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic testBoot(input logic [1:0] pr, input int nm, dn);
      len = 0;
      while (clocksReady !== 1'b1 && len < 700) begin
         tick(1);
         len++;
      end
      `CHK("ready", 500, len)
      `CHK("preset", pr, bootPreset)
      `CHK("num", nm, sysPllRatioNum)
      `CHK("den", dn, sysPllRatioDen)
      $display("boot done");
   endtask
   task automatic testPll;
      sysFeedbackSetting = 8'h27;
      lockRun(0);
      `CHK("full", 1'b1, len >= 518 && len <= 524)
      `CHK("num", 10'd80, sysPllRatioNum)
      sysExpSetting = 3'h3;
      lockRun(0);
      `CHK("short", 1'b1, len >= 9 && len <= 11)
      `CHK("den", 13'd8, sysPllRatioDen)
      apFeedbackSetting = 8'h3f;
      apReferenceDividerSetting = 5'h01;
      tick(20);
      `CHK("nokick", 10'd64, apPllRatioNum)
      lockRun(1);
      `CHK("apden", 13'd8, apPllRatioDen)
      $display("pll done");
   endtask
   task automatic testDiv;
      cpuDivSetting = 6'h05;
      sysDivSetting = 6'h07;
      kickOne(2);
      waitBusy(0);
      `CHK("divbusy", 1'b0, dividerUpdateBusy)
      period(0);
      `CHK("cpu", 6, p)
      cpuSrcSetting = 1'b1;
      sysSrcSetting = 1'b1;
      kickOne(3);
      waitBusy(1);
      `CHK("srcbusy", 1'b0, sourceUpdateBusy)
      period(0);
      `CHK("switched", 6, p)
      arrayMemDivSetting = 6'h3f;
      ifRefDivSetting = 6'h02;
      period(1);
      `CHK("div64", 64, p)
      period(3);
      `CHK("ifref", 3, p)
      period(4);
      `CHK("mem", 4, p)
      for (int c = 0; c < 3; c++) begin
         arrayCoreChoice = c[1:0];
         period(2);
         `CHK("choice", 4 - c, p)
      end
      $display("div done");
   endtask
   task automatic testWords;
      ifPllWordIn = 16'h2701;
      dispPllWordIn = 16'h1f0a;
      memPllWordIn = 16'h3b12;
      tick(1);
      `CHK("ifw", 16'h2701, ifPllWord)
      `CHK("dispw", 16'h1f0a, dispPllWord)
      `CHK("memw", 16'h3b12, memPllWord)
      $display("words done");
   endtask
   initial begin
      tick(3);
      rst = 1'b0;
      testBoot(2'h2, 64, 4);
      testPll();
      testDiv();
      testWords();
      {rst, bootCfgPins} = 3'h4;
      tick(3);
      rst = 1'b0;
      testBoot(2'h0, 148, 2);
      complete_run();
   end
   // Whole run is near 2300 cycles
   initial begin
      #800000;
      n_mismatch++;
      complete_run();
   end
endmodule // pll_timing_generator_tb
`default_nettype wire
